// file: rtl/haptic_power_params.svh
// offsets, field positions, reset values and timing counts
`ifndef HAPTIC_POWER_PARAMS_SVH
`define HAPTIC_POWER_PARAMS_SVH

// ==========================================
// register byte addresses
`define OFF_CTRL    8'h00
`define OFF_CONFIG  8'h04
`define OFF_TIMING  8'h08
`define OFF_STATUS  8'h0C

// ==========================================
// field positions
`define CTRL_GO_BIT     0
`define STAT_ACTIVE_BIT 8
`define STAT_BRAKE_BIT  9

// ==========================================
// reset values
`define CONFIG_RST  13'h0000
`define TIMING_RST  15'h0000

// ==========================================
// responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

// ==========================================
// mode codes
`define MODE_STREAM 2'h0
`define TRIG_PULSE  2'h0
`define TRIG_LEVEL  2'h1

// ==========================================
// sense timing: one field step is one unit time
`define CLK_PERIOD_NS  20
`define SENSE_UNIT_NS  100
`define SENSE_UNIT_CYC \
  ((`SENSE_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: rtl/haptic_power_pkg.sv
// types shared by the power-state and process-control logic
package haptic_power_pkg;

  typedef enum logic [1:0] {ST_STANDBY, ST_CHECK, ST_RUN, ST_BRAKE} pstate_t;
  typedef enum logic [1:0] {PH_DRIVE, PH_DECAY, PH_BLANK, PH_ZC} sense_t;

  typedef struct packed {
    logic [3:0] irq_en;
    logic       resonant_wave_shape;
    logic       open_loop_brake_en;
    logic       brake_before_idle_en;
    logic [1:0] trigger_pin_function;
    logic       closed_loop;
    logic       actuator_type_sel;
    logic [1:0] mode;
  } cfg_t;

  typedef struct packed {
    logic [4:0] drive_time;
    logic [3:0] current_decay_time;
    logic [3:0] blank_time;
    logic [1:0] zero_cross_min_time;
  } timing_t;

  typedef struct packed {
    logic process_done;
    logic undervoltage_lockout;
    logic overtemp;
    logic overcurrent_flag;
  } flags_t;

  typedef struct packed {
    logic       actuator_type_sel;
    logic       closed_loop;
    logic       resonant_wave_shape;
    logic [4:0] drive_time;
  } drive_cfg_t;

  typedef struct packed {
    pstate_t     st;
    sense_t      ph;
    logic [7:0]  cnt;
    logic        go;
    logic        trig_prev;
    cfg_t        cfg;
    timing_t     tim;
    flags_t      flags;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } state_t;

endpackage : haptic_power_pkg

// file: rtl/haptic_power_state_control.sv
// power-state sequencing, process control and back-emf window timing
// Function
// - shutdown pin low holds every block, bus slave included, in reset
// - shutdown pin release restores defaults and settles in standby
// - shutdown pin low aborts any running process at once
// - standby keeps bus access working and keeps all register contents
// - brake on standby entry when enabled, never after a critical condition
// - active state is entered only to run a process
// - critical condition at entry sets flag, irq if enabled, back to standby
// - without critical condition a routine in any mode but stream runs to completion then standby
// - critical condition during a routine aborts it, flags it, goes standby
// - stop trigger halts the routine, braking first when enabled
// - change of any mode parameter while executing aborts to standby
// - mode field picks one of four processes, started by a trigger
// - trigger pin works as pulse trigger, level trigger or interrupt
// - loop setting picks open or closed loop, type picks actuator
// - brake only if back-emf shows motion; open loop needs its enable
// - open-loop brake enable brakes on negative waveform amplitude
// - resonant wave shape applies only in open loop
// - output short during playback kills stage, flags overcurrent, standby
// - shorts are checked only at process entry and while a process runs
// - drive time gives half-period estimate or back-emf sample rate
// - sense cycle runs decay, blanking, then zero-cross windows in order
// - interrupted processes never set the process-done flag
// - critical conditions are not monitored while idle in standby
`timescale 1ns/1ps
`include "haptic_power_params.svh"

module haptic_power_state_control
  import haptic_power_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // power pin
  input  wire logic        shutdown_n_pin,
  // trigger and interrupt pin, open drain
  input  wire logic        trigger_irq_pin_in,
  output logic             trigger_irq_pin_out,
  output logic             trigger_irq_pin_oe_n,
  // analog monitors
  input  wire logic        overcurrent_det,
  input  wire logic        overtemp_det,
  input  wire logic        undervoltage_det,
  input  wire logic        output_short_det,
  input  wire logic        bemf_moving,
  // process engine
  input  wire logic        routine_done,
  input  wire logic        neg_amplitude,
  output logic             proc_run,
  output logic [1:0]       proc_mode,
  output drive_cfg_t       drive_cfg,
  output logic             output_stage_en,
  output logic             brake_active,
  output logic             decay_en,
  output logic             sense_hiz,
  output logic             zero_cross_en,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ==========================================
  // helpers
  // one-hot select: 0 ctrl, 1 config, 2 timing, 3 status
  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    reg_sel = {a == `OFF_STATUS, a == `OFF_TIMING,
               a == `OFF_CONFIG, a == `OFF_CTRL};
  endfunction : reg_sel

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) merge[8*i +: 8] = d[8*i +: 8];
    end
  endfunction : merge

  function automatic logic [7:0] win(input logic [4:0] f);
    win = 8'((16'(f) + 16'h1) * 16'(`SENSE_UNIT_CYC));
  endfunction : win

  // ==========================================
  // state
  state_t s_r, s_nxt;
  logic   rst;
  logic   wr_fire, rd_fire, rd_status;
  logic   start_req, stop_req, cfg_change, brake_ok;
  logic   pin_rise, pin_fall;
  logic   [3:0] wsel, rsel;
  logic   [2:0] crit;
  logic   [31:0] wmerged, tmerged;
  cfg_t   cfg_w;

  // shutdown pin and bus reset share one path so the bus is off too
  assign rst = !aresetn || !shutdown_n_pin;

  assign wr_fire   = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign rd_fire   = s_axi_arvalid && s_axi_arready;
  assign wsel      = reg_sel(s_r.awaddr);
  assign rsel      = reg_sel(s_axi_araddr);
  assign rd_status = rd_fire && rsel[3];
  assign wmerged   = merge({19'h0, s_r.cfg}, s_r.wdata, s_r.wstrb);
  assign tmerged   = merge({17'h0, s_r.tim}, s_r.wdata, s_r.wstrb);
  assign cfg_w     = cfg_t'(wmerged[12:0]);

  // irq enables are not mode parameters, so they may change freely
  assign cfg_change = wr_fire && wsel[1] &&
                      (cfg_w[8:0] != s_r.cfg[8:0]);

  assign pin_rise = trigger_irq_pin_in && !s_r.trig_prev;
  assign pin_fall = !trigger_irq_pin_in && s_r.trig_prev;

  always_comb begin
    start_req = wr_fire && wsel[0] && s_r.wstrb[0] && s_r.wdata[`CTRL_GO_BIT];
    stop_req  = wr_fire && wsel[0] && s_r.wstrb[0] && !s_r.wdata[`CTRL_GO_BIT];
    case (s_r.cfg.trigger_pin_function)
      `TRIG_PULSE: begin
        start_req = start_req || pin_rise;
        stop_req  = stop_req || pin_rise;
      end
      `TRIG_LEVEL: begin
        start_req = start_req || pin_rise;
        stop_req  = stop_req || pin_fall;
      end
      default: ;
    endcase
  end

  // shorts count as overcurrent; order matches flags_t
  assign crit = {undervoltage_det, overtemp_det,
                 overcurrent_det || output_short_det};

  assign brake_ok = s_r.cfg.brake_before_idle_en && bemf_moving &&
                    (s_r.cfg.closed_loop || s_r.cfg.open_loop_brake_en);

  // ==========================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.trig_prev = trigger_irq_pin_in;

    // read of status clears, but a flag set this cycle still lands
    if (rd_status) s_nxt.flags = '0;

    case (s_r.st)
      ST_STANDBY: begin
        if (start_req) begin
          s_nxt.st = ST_CHECK;
          s_nxt.go = 1'b1;
        end
      end
      ST_CHECK: begin
        if (|crit) begin
          s_nxt.flags[2:0] = s_nxt.flags[2:0] | crit;
          s_nxt.st = ST_STANDBY;
          s_nxt.go = 1'b0;
        end else begin
          s_nxt.st  = ST_RUN;
          s_nxt.ph  = PH_DRIVE;
          s_nxt.cnt = win(s_r.tim.drive_time);
        end
      end
      ST_RUN: begin
        if (|crit) begin
          s_nxt.flags[2:0] = s_nxt.flags[2:0] | crit;
          s_nxt.st = ST_STANDBY;
          s_nxt.go = 1'b0;
        end else if (cfg_change) begin
          s_nxt.st = brake_ok ? ST_BRAKE : ST_STANDBY;
          s_nxt.go = 1'b0;
        end else if (stop_req) begin
          s_nxt.st = brake_ok ? ST_BRAKE : ST_STANDBY;
          s_nxt.go = 1'b0;
        end else if (routine_done && s_r.cfg.mode != `MODE_STREAM) begin
          s_nxt.flags.process_done = 1'b1;
          s_nxt.st = brake_ok ? ST_BRAKE : ST_STANDBY;
          s_nxt.go = 1'b0;
        end
      end
      ST_BRAKE: begin
        if (!bemf_moving) s_nxt.st = ST_STANDBY;
      end
      default: s_nxt.st = ST_STANDBY;
    endcase

    // back-emf windows, closed loop only
    if (s_r.st == ST_RUN && s_r.cfg.closed_loop) begin
      if (s_r.cnt != 8'h00) begin
        s_nxt.cnt = s_r.cnt - 8'h01;
      end else begin
        case (s_r.ph)
          PH_DRIVE: begin
            s_nxt.ph  = PH_DECAY;
            s_nxt.cnt = win({1'b0, s_r.tim.current_decay_time});
          end
          PH_DECAY: begin
            s_nxt.ph  = PH_BLANK;
            s_nxt.cnt = win({1'b0, s_r.tim.blank_time});
          end
          PH_BLANK: begin
            s_nxt.ph  = PH_ZC;
            s_nxt.cnt = win({3'b000, s_r.tim.zero_cross_min_time});
          end
          default: begin
            s_nxt.ph  = PH_DRIVE;
            s_nxt.cnt = win(s_r.tim.drive_time);
          end
        endcase
      end
    end

    // ---- axi write: address and data accepted in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_fire) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = (|wsel) ? `RESP_OKAY : `RESP_SLVERR;
      if (wsel[1]) s_nxt.cfg = cfg_w;
      if (wsel[2]) s_nxt.tim = timing_t'(tmerged[14:0]);
    end
    if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;

    // ---- axi read
    if (rd_fire) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = (|rsel) ? `RESP_OKAY : `RESP_SLVERR;
      s_nxt.rdata  = 32'h0000_0000;
      if (rsel[0]) s_nxt.rdata[`CTRL_GO_BIT] = s_r.go;
      if (rsel[1]) s_nxt.rdata[12:0] = s_r.cfg;
      if (rsel[2]) s_nxt.rdata[14:0] = s_r.tim;
      if (rsel[3]) begin
        s_nxt.rdata[3:0] = s_r.flags;
        s_nxt.rdata[`STAT_ACTIVE_BIT] = s_r.st != ST_STANDBY;
        s_nxt.rdata[`STAT_BRAKE_BIT]  = s_r.st == ST_BRAKE;
      end
    end else if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      s_r <= '{st: ST_STANDBY, ph: PH_DRIVE, cfg: cfg_t'(`CONFIG_RST),
               tim: timing_t'(`TIMING_RST), trig_prev: 1'b1, default: '0};  // pin idles high
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // outputs
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = s_r.rdata;

  assign proc_run  = s_r.st == ST_RUN;
  assign proc_mode = s_r.cfg.mode;
  assign drive_cfg = '{actuator_type_sel: s_r.cfg.actuator_type_sel,
                       closed_loop: s_r.cfg.closed_loop,
                       resonant_wave_shape: s_r.cfg.resonant_wave_shape &&
                                            !s_r.cfg.closed_loop,
                       drive_time: s_r.tim.drive_time};

  // short gates the stage in the same cycle it is seen
  assign output_stage_en = proc_run && s_r.ph == PH_DRIVE &&
                           !output_short_det;
  assign brake_active = s_r.st == ST_BRAKE ||
                        (proc_run && !s_r.cfg.closed_loop &&
                         s_r.cfg.open_loop_brake_en && neg_amplitude);
  assign decay_en      = proc_run && s_r.ph == PH_DECAY;
  assign sense_hiz     = proc_run && (s_r.ph == PH_BLANK || s_r.ph == PH_ZC);
  assign zero_cross_en = proc_run && s_r.ph == PH_ZC;

  // pin pulls low only in interrupt function
  assign trigger_irq_pin_out  = 1'b0;
  assign trigger_irq_pin_oe_n = !(s_r.cfg.trigger_pin_function[1] &&
                                  |(s_r.flags & s_r.cfg.irq_en));

  // ==========================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (rst);

  sequence s_check_bad;
    s_r.st == ST_CHECK && |crit;
  endsequence
  sequence s_back_standby;
    s_r.st == ST_STANDBY && !s_r.go;
  endsequence

  property p_shutdown;
    @(posedge aclk) disable iff (!aresetn)
    !shutdown_n_pin |=> s_back_standby ##0 !s_axi_bvalid && !proc_run;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown not held");
  property p_check_crit;
    s_check_bad |=> s_back_standby ##0 ((s_r.flags[2:0] & $past(crit)) == $past(crit));
  endproperty
  a_check_crit: assert property (p_check_crit) else $error("critical at entry");
  property p_check_ok;
    s_r.st == ST_CHECK && !(|crit) |=> proc_run ##1 (proc_run || !s_r.go);
  endproperty
  a_check_ok: assert property (p_check_ok) else $error("routine not started");
  property p_run_crit;
    proc_run && |crit |=> s_back_standby ##0 !brake_active;
  endproperty
  a_run_crit: assert property (p_run_crit) else $error("critical abort failed");
  property p_stop_brake;
    proc_run && !(|crit) && !cfg_change && stop_req && brake_ok |=> s_r.st == ST_BRAKE;
  endproperty
  a_stop_brake: assert property (p_stop_brake) else $error("no brake on stop");
  property p_cfg_abort;
    proc_run && !(|crit) && cfg_change |=> !s_r.go && !s_r.flags.process_done &&
      s_r.st == ($past(brake_ok) ? ST_BRAKE : ST_STANDBY);
  endproperty
  a_cfg_abort: assert property (p_cfg_abort) else $error("mode change not abort");
  property p_idle_quiet;
    s_r.st == ST_STANDBY && !rd_status |=> s_r.flags == $past(s_r.flags);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("flag moved in standby");
  property p_flag_hold;
    |s_r.flags[2:0] && !rd_status |=> |s_r.flags[2:0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost before read");
  property p_short_off;
    output_short_det |-> !output_stage_en;
  endproperty
  a_short_off: assert property (p_short_off) else $error("stage on with short");
  property p_sense_order;
    proc_run && s_r.ph == PH_BLANK && $past(s_r.ph) != PH_BLANK |-> $past(s_r.ph) == PH_DECAY;
  endproperty
  a_sense_order: assert property (p_sense_order) else $error("window order");

endmodule : haptic_power_state_control

// file: tb/haptic_far_side_model.sv
// far side model: process engine, actuator motion and the pulled-up trigger wire
`timescale 1ns/1ps

module haptic_far_side_model (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // bench controls
  input  wire logic host_drive,
  input  wire logic host_level,
  input  wire logic spin_en,
  input  wire logic finish_en,
  // device side
  input  wire logic proc_run,
  input  wire logic brake_active,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output logic      pin_wire,
  output logic      routine_done,
  output logic      bemf_moving
);
  // ==========================================
  // engine and actuator
  localparam int RUN_CYC = 20;
  int run_cnt;
  int brk_cnt;

  // pull-up: the wire is low only while some party drives it low
  assign pin_wire = (pin_oe_n ? 1'b1 : pin_out) & (host_drive ? host_level : 1'b1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_cnt      <= 0;
      brk_cnt      <= 0;
      routine_done <= 1'b0;
      bemf_moving  <= 1'b0;
    end else begin
      run_cnt      <= proc_run ? run_cnt + 1 : 0;
      routine_done <= finish_en && proc_run && (run_cnt == RUN_CYC);
      brk_cnt      <= brake_active ? brk_cnt + 1 : 0;
      // the actuator keeps spinning after a run until braked or let go
      if (proc_run && spin_en) begin
        bemf_moving <= 1'b1;
      end else if (brk_cnt == 3 || !spin_en) begin
        bemf_moving <= 1'b0;
      end
    end
  end
endmodule : haptic_far_side_model

// file: tb/haptic_power_state_control_tb_top.sv
// self-checking bench for the power-state and process-control block
`timescale 1ns/1ps
`include "haptic_power_params.svh"

module haptic_power_state_control_tb_top;
  import haptic_power_pkg::*;

  // ==========================================
  // signals
  logic        aclk, aresetn, shutdown_n_pin, neg_amplitude;
  logic [3:0]  crit;
  logic        host_drive, host_level, spin_en, finish_en;
  logic        pin_wire, pin_out, pin_oe_n, routine_done, bemf_moving;
  logic        proc_run, output_stage_en, brake_active, decay_en, sense_hiz, zero_cross_en;
  logic [1:0]  proc_mode;
  drive_cfg_t  drive_cfg;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, rs;
  int          err_count, comparisons;

  always #10 aclk = ~aclk;

  haptic_power_state_control dut_u (
    .aclk(aclk), .aresetn(aresetn), .shutdown_n_pin(shutdown_n_pin),
    .trigger_irq_pin_in(pin_wire), .trigger_irq_pin_out(pin_out),
    .trigger_irq_pin_oe_n(pin_oe_n), .overcurrent_det(crit[0]), .overtemp_det(crit[1]),
    .undervoltage_det(crit[2]), .output_short_det(crit[3]), .bemf_moving(bemf_moving),
    .routine_done(routine_done), .neg_amplitude(neg_amplitude), .proc_run(proc_run),
    .proc_mode(proc_mode), .drive_cfg(drive_cfg), .output_stage_en(output_stage_en),
    .brake_active(brake_active), .decay_en(decay_en), .sense_hiz(sense_hiz),
    .zero_cross_en(zero_cross_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  haptic_far_side_model far_u (
    .aclk(aclk), .aresetn(aresetn), .host_drive(host_drive), .host_level(host_level),
    .spin_en(spin_en), .finish_en(finish_en), .proc_run(proc_run),
    .brake_active(brake_active), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_wire(pin_wire), .routine_done(routine_done), .bemf_moving(bemf_moving));

  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // outputs are read right at the edge, so they show the settled previous cycle
  function automatic logic sig(input int sel);
    case (sel)
      0: return brake_active;
      1: return decay_en;
      2: return sense_hiz;
      3: return zero_cross_en;
      default: return proc_run;
    endcase
  endfunction : sig

  task automatic await(input int sel, input logic lvl);
    int n;
    n = 0;
    while (sig(sel) !== lvl && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk(sig(sel), lvl);
  endtask : await

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) rs = bresp;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    if (n >= 50) err_count++;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) rv = rdata;
      if (rvalid) rs = rresp;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    if (n >= 50) err_count++;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rv, exp);
  endtask : rchk

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // whole run is well under a thousand cycles; a limit of 20000 cycles means a hang
  initial begin
    #400000;
    err_count++;
    summarize();
  end

  // ==========================================
  // tests
  initial begin
    {aclk, aresetn, neg_amplitude, crit, host_level, spin_en, finish_en} = '0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {err_count, comparisons} = '0;
    shutdown_n_pin = 1'b1;
    host_drive     = 1'b1;
    wstrb          = 4'hF;
    cyc(5);
    aresetn <= 1'b1;
    rchk(`OFF_CONFIG, 32'h0);
    rchk(`OFF_TIMING, 32'h0);
    rchk(`OFF_STATUS, 32'h0);
    rd(8'h10);
    chk(rs, `RESP_SLVERR);
    wr(8'h10, 32'hFFFFFFFF);
    chk(rs, `RESP_SLVERR);
    wr(`OFF_TIMING, 32'h00007FFF);
    rchk(`OFF_TIMING, 32'h00007FFF);
    chk(drive_cfg.drive_time, 32'h1F);
    wr(`OFF_TIMING, 32'h0);
    wr(`OFF_CONFIG, 32'h0000010C);
    chk(drive_cfg, 32'hC0);
    wr(`OFF_CONFIG, 32'h00000104);
    chk(drive_cfg, 32'hA0);
    // sequencer, diagnostics and calibration each finish by themselves
    finish_en <= 1'b1;
    for (int m = 1; m < 4; m++) begin
      wr(`OFF_CONFIG, m);
      chk(proc_run, 1'b0);
      wr(`OFF_CTRL, 32'h1);
      cyc(3);
      chk(proc_run, 1'b1);
      chk(proc_mode, m);
      cyc(30);
      chk(proc_run, 1'b0);
      rchk(`OFF_STATUS, 32'h8);
    end
    finish_en <= 1'b0;
    wr(`OFF_CONFIG, 32'h0);
    wr(`OFF_CTRL, 32'h1);
    cyc(3);
    rchk(`OFF_CTRL, 32'h1);
    wr(`OFF_CTRL, 32'h0);
    cyc(3);
    chk(proc_run, 1'b0);
    rchk(`OFF_STATUS, 32'h0);
    // each critical source: ignored idle, caught at entry and mid-run
    spin_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_CONFIG, 32'h48);
      crit <= 4'h1 << i;
      cyc(5);
      rchk(`OFF_STATUS, 32'h0);
      wr(`OFF_CTRL, 32'h1);
      cyc(4);
      chk(proc_run, 1'b0);
      rchk(`OFF_STATUS, (i == 3) ? 32'h1 : (32'h1 << i));
      crit <= 4'h0;
      wr(`OFF_CTRL, 32'h1);
      cyc(3);
      crit <= 4'h1 << i;
      cyc(2);
      chk(proc_run, 1'b0);
      chk(brake_active, 1'b0);
      crit <= 4'h0;
      cyc(5);
      rchk(`OFF_STATUS, (i == 3) ? 32'h1 : (32'h1 << i));
      rchk(`OFF_STATUS, 32'h0);
    end
    wr(`OFF_CTRL, 32'h1);
    cyc(3);
    wr(`OFF_CTRL, 32'h0);
    await(0, 1'b1);
    await(0, 1'b0);
    chk(proc_run, 1'b0);
    wr(`OFF_CONFIG, 32'h40);
    wr(`OFF_CTRL, 32'h1);
    cyc(3);
    wr(`OFF_CTRL, 32'h0);
    cyc(4);
    chk(brake_active, 1'b0);
    wr(`OFF_CONFIG, 32'hC0);
    wr(`OFF_CTRL, 32'h1);
    cyc(3);
    chk(output_stage_en, 1'b1);
    neg_amplitude <= 1'b1;
    cyc(2);
    chk(brake_active, 1'b1);
    neg_amplitude <= 1'b0;
    cyc(2);
    chk(brake_active, 1'b0);
    wr(`OFF_CONFIG, 32'h80);
    cyc(2);
    chk(proc_run, 1'b0);
    chk(brake_active, 1'b1);
    await(0, 1'b0);
    rchk(`OFF_STATUS, 32'h0);
    spin_en <= 1'b0;
    // back-emf sense windows in closed loop
    wr(`OFF_CONFIG, 32'h08);
    wr(`OFF_CTRL, 32'h1);
    await(1, 1'b1);
    chk(output_stage_en, 1'b0);
    chk(sense_hiz, 1'b0);
    await(2, 1'b1);
    chk(zero_cross_en, 1'b0);
    await(3, 1'b1);
    chk(decay_en, 1'b0);
    wr(`OFF_CTRL, 32'h0);
    // pin as pulse trigger, level trigger, then interrupt output
    wr(`OFF_CONFIG, 32'h0);
    host_level <= 1'b1;
    cyc(2);
    host_level <= 1'b0;
    await(4, 1'b1);
    cyc(2);
    host_level <= 1'b1;
    cyc(2);
    host_level <= 1'b0;
    await(4, 1'b0);
    wr(`OFF_CONFIG, 32'h10);
    host_level <= 1'b1;
    await(4, 1'b1);
    host_level <= 1'b0;
    await(4, 1'b0);
    wr(`OFF_CONFIG, 32'h1E20);
    host_drive <= 1'b0;
    crit       <= 4'h1;
    wr(`OFF_CTRL, 32'h1);
    cyc(4);
    chk(pin_wire, 1'b0);
    rchk(`OFF_STATUS, 32'h1);
    crit <= 4'h0;
    cyc(2);
    chk(pin_wire, 1'b1);
    host_drive <= 1'b1;
    // shutdown pin mid-run
    wr(`OFF_CONFIG, 32'h1);
    wr(`OFF_CTRL, 32'h1);
    cyc(3);
    shutdown_n_pin <= 1'b0;
    cyc(2);
    chk(proc_run, 1'b0);
    shutdown_n_pin <= 1'b1;
    rchk(`OFF_CONFIG, 32'h0);
    rchk(`OFF_STATUS, 32'h0);
    summarize();
  end
endmodule : haptic_power_state_control_tb_top
